// *** pmc_regs.svh ***
// register map, field positions, reset values and timing constants of the power mode controller
// Behaviour
// - power control register sits at 0x87, accessed only as a whole byte
// - writing 1 to bit 0 enters idle: cpu clock gated, peripherals clocked
// - writing 1 to bit 1 enters power-down: all clocks stopped
// - both request bits written together: power-down wins over idle
// - reset clears baud doubler and bits 3..0
// - baud doubler bit 7 tells the serial port to double its rate
// - bits 3 and 2 are plain software flags without hardware effect
// - last write before idle stops the cpu; all state is kept during idle
// - any enabled interrupt clears the idle request and ends idle
// - last write before power-down stops the oscillator; state is kept
// - power-down ends only by hardware reset; interrupts do not end it
// - in idle both strobes read 1, port 0 floats, port 2 drives address only with ext_prog set, else its latch
// - in power-down both strobes read 0, port 0 floats, port 2 drives latch
// - contents are kept when the clock is slowed or stopped
// - address strobe pulses at 1/6 oscillator rate, one pulse skipped per data access
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_POWER_CONTROL_ADDR 12'h21c
`define PMC_POWER_CONTROL_INDEX 8'h87
`define PMC_STAT_ADDR 12'h220
`define PMC_BIT_IDLE 0
`define PMC_BIT_PDOWN 1
`define PMC_BIT_UF0 2
`define PMC_BIT_UF1 3
`define PMC_BIT_BAUD 7
`define PMC_WMASK 8'h8f
`define PMC_RESET 8'h00
`define PMC_ALE_DIV 3'h6
`define PMC_ALE_LAST 3'h5
`define PMC_CODE_FETCH_STROBE_A 3'h2
`define PMC_CODE_FETCH_STROBE_B 3'h5
`endif

// *** pmc_pkg.sv ***
// types shared by the power mode controller files
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_RUN = 2'b00,
    PMC_IDLE = 2'b01,
    PMC_PDOWN = 2'b10
  } pmc_mode_t;
endpackage

// *** pmc_strobe_gen.sv ***
`timescale 1ns/1ps
// address latch and code fetch strobe generator, one state per oscillator period
`include "pmc_regs.svh"
module pmc_strobe_gen
(
  input wire logic pclk, // oscillator-rate clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic run, // strobes run only while not in a low power mode
  input wire logic skip, // external data access: drop one address strobe
  input wire logic ext_fetch, // fetching from external program memory
  output logic ale, // address latch strobe
  output logic code_fetch_strobe // code fetch strobe, active high here
);
  logic [2:0] phase_reg;
  logic [2:0] phase_next;
  logic ale_next;
  logic code_fetch_strobe_next;
  logic skip_pend_reg;
  logic skip_pend_next;

  // phase counter wraps every six periods; a skip request is held until the next pulse slot
  always_comb
  begin
    phase_next = (phase_reg == `PMC_ALE_LAST) ? 3'h0 : phase_reg + 3'h1;
    skip_pend_next = skip_pend_reg | skip;
    ale_next = 1'b0;
    code_fetch_strobe_next = 1'b0;
    if (!run)
    begin
      phase_next = phase_reg;
      skip_pend_next = skip_pend_reg;
    end
    else if (phase_reg == 3'h0)
    begin
      ale_next = !skip_pend_next;
      skip_pend_next = 1'b0;
    end
    if (run && ext_fetch && (phase_reg == `PMC_CODE_FETCH_STROBE_A || phase_reg == `PMC_CODE_FETCH_STROBE_B))
      code_fetch_strobe_next = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= 3'h0;
      skip_pend_reg <= 1'b0;
      ale <= 1'b0;
      code_fetch_strobe <= 1'b0;
    end
    else if (ce)
    begin
      phase_reg <= phase_next;
      skip_pend_reg <= skip_pend_next;
      ale <= ale_next;
      code_fetch_strobe <= code_fetch_strobe_next;
    end
  end
endmodule

// *** pmc_power_ctrl.sv ***
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// power mode controller: power control register on apb, mode state and pin states
`include "pmc_regs.svh"
module pmc_power_ctrl
(
  input wire logic pclk, // oscillator-rate clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state while low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic irq_pending, // an enabled interrupt is asserted
  input wire logic ext_prog, // cpu runs from external program memory
  input wire logic ext_data_access, // one-cycle pulse per external data access
  output logic cpu_clk_en, // cpu clock gate enable
  output logic periph_clk_en, // timers, serial, interrupt clock enable
  output logic osc_en, // oscillator enable
  output logic baud_doubler, // serial port double rate
  output logic ale_out, // address latch strobe pin
  output logic code_fetch_strobe_n, // code fetch strobe pin, active low
  output logic port0_oe, // port 0 driver enable, low = floating
  output logic high_addr_sel // port 2 shows address (1) or its latch (0)
);
  import pmc_pkg::*;

  logic [7:0] power_control_reg;
  logic [7:0] power_control_next;
  pmc_mode_t mode_reg;
  pmc_mode_t mode_next;
  logic [31:0] prdata_next;
  logic pslverr_next;
  logic pready_next;
  logic irq_s1_reg;
  logic irq_s2_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic dx_s1_reg;
  logic dx_s2_reg;
  logic cpu_clk_en_next;
  logic periph_clk_en_next;
  logic osc_en_next;
  logic ale_next;
  logic code_fetch_strobe_n_next;
  logic p0_oe_next;
  logic hi_sel_next;
  logic ale_raw;
  logic code_fetch_strobe_raw;
  logic wr_power_control;
  logic [7:0] wbyte;

  // address decode used by both the read and write paths
  function automatic logic is_power_control(input logic [11:0] a);
    is_power_control = (a == `PMC_POWER_CONTROL_ADDR);
  endfunction

  function automatic logic is_stat(input logic [11:0] a);
    is_stat = (a == `PMC_STAT_ADDR);
  endfunction

  // pins arrive from outside the clock domain, so two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_s1_reg <= 1'b0;
      irq_s2_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      dx_s1_reg <= 1'b0;
      dx_s2_reg <= 1'b0;
    end
    else if (ce)
    begin
      irq_s1_reg <= irq_pending;
      irq_s2_reg <= irq_s1_reg;
      ext_s1_reg <= ext_prog;
      ext_s2_reg <= ext_s1_reg;
      dx_s1_reg <= ext_data_access;
      dx_s2_reg <= dx_s1_reg;
    end
  end

  // writes land on the access phase; only the whole byte is written
  assign wr_power_control = psel && penable && pwrite && is_power_control(paddr);
  assign wbyte = pwdata[7:0] & `PMC_WMASK;

  // register and mode next-state logic
  always_comb
  begin
    power_control_next = power_control_reg;
    mode_next = mode_reg;
    if (wr_power_control && mode_reg == PMC_RUN)
      power_control_next = wbyte;
    case (mode_reg)
      PMC_RUN:
      begin
        if (wr_power_control && wbyte[`PMC_BIT_PDOWN])
          mode_next = PMC_PDOWN;
        else if (wr_power_control && wbyte[`PMC_BIT_IDLE])
          mode_next = PMC_IDLE;
      end
      PMC_IDLE:
      begin
        // an interrupt wakes the cpu; the request bit clears in the same edge
        if (irq_s2_reg)
        begin
          mode_next = PMC_RUN;
          power_control_next[`PMC_BIT_IDLE] = 1'b0;
        end
      end
      PMC_PDOWN:
      begin
        // nothing but presetn leaves this state; register contents are held
        mode_next = PMC_PDOWN;
      end
      default:
      begin
        mode_next = PMC_RUN;
      end
    endcase
  end

  // apb read answer, zero-wait; unmapped addresses answer with an error
  always_comb
  begin
    prdata_next = 32'h0000_0000;
    pslverr_next = 1'b0;
    pready_next = 1'b0;
    if (psel && !penable)
    begin
      pready_next = 1'b1;
      if (is_power_control(paddr))
        prdata_next = {24'h00_0000, power_control_reg & `PMC_WMASK};
      else if (is_stat(paddr))
        prdata_next = {30'h0000_0000, mode_reg};
      else
        pslverr_next = 1'b1;
    end
  end

  // pin states per mode; the cpu clock stops but register state is kept
  always_comb
  begin
    cpu_clk_en_next = (mode_next == PMC_RUN);
    periph_clk_en_next = (mode_next != PMC_PDOWN);
    osc_en_next = (mode_next != PMC_PDOWN);
    ale_next = ale_raw;
    code_fetch_strobe_n_next = !code_fetch_strobe_raw;
    p0_oe_next = ext_s2_reg && code_fetch_strobe_raw;
    hi_sel_next = ext_s2_reg;
    case (mode_next)
      PMC_IDLE:
      begin
        ale_next = 1'b1;
        code_fetch_strobe_n_next = 1'b1;
        p0_oe_next = 1'b0;
        hi_sel_next = ext_s2_reg;
      end
      PMC_PDOWN:
      begin
        ale_next = 1'b0;
        code_fetch_strobe_n_next = 1'b0;
        p0_oe_next = 1'b0;
        hi_sel_next = 1'b0;
      end
      default:
      begin
        ale_next = ale_raw;
      end
    endcase
  end

  pmc_strobe_gen u_strobe
  (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(mode_reg == PMC_RUN),
    .skip(dx_s2_reg),
    .ext_fetch(ext_s2_reg),
    .ale(ale_raw),
    .code_fetch_strobe(code_fetch_strobe_raw)
  );

  // state registers; ce low freezes everything, which also keeps state at any rate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_control_reg <= `PMC_RESET;
      mode_reg <= PMC_RUN;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
      baud_doubler <= 1'b0;
      ale_out <= 1'b0;
      code_fetch_strobe_n <= 1'b1;
      port0_oe <= 1'b0;
      high_addr_sel <= 1'b0;
    end
    else if (ce)
    begin
      power_control_reg <= power_control_next;
      mode_reg <= mode_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      cpu_clk_en <= cpu_clk_en_next;
      periph_clk_en <= periph_clk_en_next;
      osc_en <= osc_en_next;
      baud_doubler <= power_control_next[`PMC_BIT_BAUD];
      ale_out <= ale_next;
      code_fetch_strobe_n <= code_fetch_strobe_n_next;
      port0_oe <= p0_oe_next;
      high_addr_sel <= hi_sel_next;
    end
  end
endmodule

// *** pmc_properties.sv ***
// concurrent checks on the power mode controller ports
`timescale 1ns/1ps
module pmc_properties
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic ce, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic irq_pending, // interrupt pending
  input wire logic cpu_clk_en, // cpu clock gate
  input wire logic periph_clk_en, // peripheral clock gate
  input wire logic osc_en, // oscillator enable
  input wire logic ale_out, // address strobe
  input wire logic code_fetch_strobe_n // fetch strobe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic in_idle = osc_en && !cpu_clk_en;
  // a write of both request bits while the cpu still runs
  sequence both_write;
    psel && penable && pready && pwrite && paddr == 12'h21c && pwdata[1:0] == 2'h3 && cpu_clk_en;
  endsequence
  // pending interrupt held through the two synchroniser flops and the mode flop
  sequence irq_wait;
    (ce && in_idle && irq_pending) [*3];
  endsequence
  apb_ready_a: assert property (psel && !penable && ce |=> pready)
    else $error("apb access not answered");
  read_mask_a: assert property (pready && !pwrite && paddr == 12'h21c |->
    prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0) else $error("reserved bits read set");
  idle_periph_a: assert property (in_idle |-> periph_clk_en)
    else $error("peripherals stopped in idle");
  pdown_clocks_a: assert property (!osc_en |-> !cpu_clk_en && !periph_clk_en)
    else $error("clock running in power-down");
  pdown_wins_a: assert property (both_write |=> !osc_en)
    else $error("power-down lost to idle");
  idle_pins_a: assert property (in_idle |-> ale_out && code_fetch_strobe_n)
    else $error("strobes not high in idle");
  pdown_pins_a: assert property (!osc_en |-> !ale_out && !code_fetch_strobe_n)
    else $error("strobes not low in power-down");
  pdown_hold_a: assert property (!osc_en |=> $stable(osc_en))
    else $error("power-down left without reset");
  idle_exit_a: assert property (irq_wait |=> cpu_clk_en)
    else $error("interrupt did not end idle");
endmodule

// *** tb_power_mode_control.sv ***
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb_power_mode_control;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, d, seed = 32'h8679db47;
  logic pready, pslverr, err, irq_pending = 1'b0, ext_prog = 1'b0, ext_data_access = 1'b0;
  logic cpu_clk_en, periph_clk_en, osc_en, baud_doubler, ale_out, code_fetch_strobe_n;
  logic port0_oe, high_addr_sel;
  int num_errors = 0, checks = 0, cycles = 0, n;
  pmc_power_ctrl pmc_power_ctrl_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_pending, .ext_prog, .ext_data_access,
    .cpu_clk_en, .periph_clk_en, .osc_en, .baud_doubler, .ale_out, .code_fetch_strobe_n,
    .port0_oe, .high_addr_sel);
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  // xorshift keeps the random stream repeatable
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // readback of a write with bits 1..0 clear: only the baud bit and the two flags survive
  function automatic logic [31:0] rb(input logic [31:0] v);
    return {24'h0, v[7:0] & 8'h8c};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; the request is held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic count_ale;
    n = 0;
    repeat (60)
    begin
      @(posedge pclk);
      n += ale_out;
      ext_data_access <= 1'b0;
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // a hang is cut short well beyond the few hundred cycles the tests need
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h21c, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check(err, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 9; i++)
    begin
      seed = xs(seed);
      d = (i == 0) ? 32'hfc : seed & 32'hfffffffc;
      apb(1'b1, 12'h21c, d);
      apb(1'b0, 12'h21c, 32'h0);
      check(rd, rb(d));
      check(baud_doubler, d[7]);
    end
    // clock enable low must freeze the register contents
    ce <= 1'b0;
    repeat (8) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, 12'h21c, 32'h0);
    check(rd, rb(d));
    $display("test flags done");
    ext_prog <= 1'b1;
    count_ale();
    check(n, 32'ha);
    ext_data_access <= 1'b1;
    count_ale();
    check(n, 32'h9);
    $display("test strobe done");
    apb(1'b1, 12'h21c, 32'h0d);
    @(negedge pclk);
    check({cpu_clk_en, periph_clk_en, ale_out, code_fetch_strobe_n, port0_oe, high_addr_sel},
      32'h1d);
    apb(1'b0, 12'h220, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, 12'h21c, 32'h80);
    apb(1'b0, 12'h21c, 32'h0);
    check(rd, 32'h0d);
    irq_pending <= 1'b1;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    irq_pending <= 1'b0;
    apb(1'b0, 12'h21c, 32'h0);
    check(rd, 32'h0c);
    $display("test idle done");
    apb(1'b1, 12'h21c, 32'h03);
    @(negedge pclk);
    check({osc_en, cpu_clk_en, periph_clk_en, ale_out, code_fetch_strobe_n, high_addr_sel},
      32'h0);
    apb(1'b0, 12'h220, 32'h0);
    check(rd, 32'h2);
    irq_pending <= 1'b1;
    repeat (10) @(posedge pclk);
    check(osc_en, 32'h0);
    irq_pending <= 1'b0;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h21c, 32'h0);
    check({osc_en, rd[30:0]}, 32'h80000000);
    $display("test power-down done");
    final_report();
  end
endmodule
bind pmc_power_ctrl pmc_properties pmc_properties_i (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .irq_pending, .cpu_clk_en, .periph_clk_en,
  .osc_en, .ale_out, .code_fetch_strobe_n);
